// >>> cpst_pkg.sv
// Purpose: constants and carriers for the camera picture sequence timer
// Assumes: core_clk at 100 MHz, times counted in clock cycles
// Notes: long counts are top-level parameters derived from these defaults
//
// Functional notes
// [R1] start pulse launches one 208 s cycle
// [R2] first 8 s: prepare, expose, develop in order
// [R3] then 200 s readout scanning image out
// [R4] command side sends expose at 5.5 s
// [R5] expose pulse in prepare phase fires shutter
// [R6] no expose pulse: backup shutter at 5.5625 s
// [R7] after readout, hold idle indefinitely
// [R8] only start pulse ends the hold
// [R9] command side repeats pulses every orbit
// [R10] sampling pulses only during readout
// [R11] durations counted on reference clock, cleared at start
// [R12] shutter at most once per cycle
package cpst_pkg;

	localparam longint CLK_HZ          = 100_000_000;
	localparam longint CLK_PERIOD_NS   = 1_000_000_000 / CLK_HZ;

	// times in microseconds as documented
	localparam longint FRONT_US        = 8_000_000;
	localparam longint READOUT_US      = 200_000_000;
	localparam longint BACKUP_US       = 5_562_500;
	localparam longint PREPARE_US      = 5_500_000;
	localparam longint SAMPLE_PERIOD_US = 1000;

	// cycle counts (least times round up)
	localparam longint FRONT_CYC       = (FRONT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam longint READOUT_CYC     = (READOUT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam longint BACKUP_CYC      = (BACKUP_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam longint PREPARE_CYC     = (PREPARE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam longint SAMPLE_CYC      = (SAMPLE_PERIOD_US * 1000 + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;

	localparam int CNT_W = 36;
	localparam int SMP_W = 20;

	typedef enum logic [2:0] {
		ST_HOLD,
		ST_PREPARE,
		ST_EXPOSE,
		ST_DEVELOP,
		ST_READOUT
	} cpst_state_t;

	typedef struct packed {
		logic shutter_trigger;
		logic sampling_pulse;
		logic prepare_active;
		logic expose_active;
		logic develop_active;
		logic readout_active;
		logic hold_active;
	} cpst_out_t;

	typedef struct packed {
		cpst_state_t      st;
		logic [CNT_W-1:0] cnt;
		logic [SMP_W-1:0] smp_cnt;
		logic             fired;
		logic [1:0]       start_sync;
		logic [1:0]       expose_sync;
		logic             start_d;
		logic             expose_d;
		cpst_out_t        out;
	} cpst_regs_t;

endpackage

// >>> cpst_timer.sv
// Purpose: picture cycle sequencer: prepare/expose/develop then readout, then hold
// Assumes: start and expose pulses are asynchronous pins, rising edge meaningful
// Notes: durations are parameters so simulation can shorten them
// Notes: a start edge in any state restarts the whole cycle
// Notes: late or repeated expose edges are dropped silently
`timescale 1ns/1ns
module cpst_timer #(
	parameter logic [35:0] FRONT_CYC   = 36'(cpst_pkg::FRONT_CYC),
	parameter logic [35:0] READOUT_CYC = 36'(cpst_pkg::READOUT_CYC),
	parameter logic [35:0] BACKUP_CYC  = 36'(cpst_pkg::BACKUP_CYC),
	parameter logic [35:0] PREPARE_CYC = 36'(cpst_pkg::PREPARE_CYC),
	parameter logic [19:0] SAMPLE_CYC  = 20'(cpst_pkg::SAMPLE_CYC)
) (
	// clock and reset
	input  wire logic                 core_clk,
	input  wire logic                 srst,
	// command side pins
	input  wire logic                 cycle_start_pulse,
	input  wire logic                 expose_pulse,
	// camera controls and phase status
	output cpst_pkg::cpst_out_t       cam_out
);

	cpst_pkg::cpst_regs_t r_r;
	cpst_pkg::cpst_regs_t r_nxt;
	logic                 start_edge;
	logic                 expose_edge;

	////////////////////////////////////////////////////////////////////////
	// helpers

	// true on the last count of a span of lim cycles
	function automatic logic cnt_reached(
		input logic [cpst_pkg::CNT_W-1:0] cnt,
		input logic [cpst_pkg::CNT_W-1:0] lim
	);
		logic [cpst_pkg::CNT_W-1:0] last;
		last = lim - 36'h1;
		return cnt >= last;
	endfunction

	// true on the last count of a sampling period
	function automatic logic smp_reached(
		input logic [cpst_pkg::SMP_W-1:0] cnt,
		input logic [cpst_pkg::SMP_W-1:0] lim
	);
		logic [cpst_pkg::SMP_W-1:0] last;
		last = lim - 20'h1;
		return cnt >= last;
	endfunction

	// phase counter advance
	function automatic logic [cpst_pkg::CNT_W-1:0] cnt_step(
		input logic [cpst_pkg::CNT_W-1:0] cnt
	);
		return cnt + 36'h1;
	endfunction

	// shift a pin into its two-stage synchroniser
	function automatic logic [1:0] sync_step(
		input logic [1:0] cur,
		input logic       pin
	);
		return {cur[0], pin};
	endfunction

	// rising edge from the synchronised level and its delayed copy
	function automatic logic rise_seen(
		input logic now_lvl,
		input logic was_lvl
	);
		return now_lvl & ~was_lvl;
	endfunction

	// one-hot phase levels for a state, with the two pulses passed through
	function automatic cpst_pkg::cpst_out_t phase_flags(
		input cpst_pkg::cpst_state_t st,
		input logic                  shutter,
		input logic                  sample
	);
		cpst_pkg::cpst_out_t o;
		o                 = '0;
		o.shutter_trigger = shutter;
		o.sampling_pulse  = sample;
		case (st)
			cpst_pkg::ST_HOLD: begin
				o.hold_active = 1'b1;
			end
			cpst_pkg::ST_PREPARE: begin
				o.prepare_active = 1'b1;
			end
			cpst_pkg::ST_EXPOSE: begin
				o.expose_active = 1'b1;
			end
			cpst_pkg::ST_DEVELOP: begin
				o.develop_active = 1'b1;
			end
			cpst_pkg::ST_READOUT: begin
				o.readout_active = 1'b1;
			end
			default: begin
				o.hold_active = 1'b1;
			end
		endcase
		return o;
	endfunction

	// start edge: back to prepare with counters and trigger history cleared
	function automatic cpst_pkg::cpst_regs_t restart_cycle(
		input cpst_pkg::cpst_regs_t cur
	);
		cpst_pkg::cpst_regs_t v;
		v                     = cur;
		v.st                  = cpst_pkg::ST_PREPARE; // [R1] [R8]
		v.cnt                 = '0; // [R11]
		v.smp_cnt             = '0;
		v.fired               = 1'b0;
		v.out.shutter_trigger = 1'b0;
		v.out.sampling_pulse  = 1'b0;
		return v;
	endfunction

	// state after reset: holding, pins seen low, nothing fired
	function automatic cpst_pkg::cpst_regs_t reset_regs();
		cpst_pkg::cpst_regs_t v;
		v             = '0;
		v.st          = cpst_pkg::ST_HOLD;
		v.cnt         = '0;
		v.smp_cnt     = '0;
		v.fired       = 1'b0;
		v.start_sync  = 2'h0;
		v.expose_sync = 2'h0;
		v.start_d     = 1'b0;
		v.expose_d    = 1'b0;
		v.out         = phase_flags(cpst_pkg::ST_HOLD, 1'b0, 1'b0);
		return v;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// edge detect on synchronised pins
	assign start_edge  = rise_seen(r_r.start_sync[1], r_r.start_d);
	assign expose_edge = rise_seen(r_r.expose_sync[1], r_r.expose_d);

	////////////////////////////////////////////////////////////////////////
	// next state
	always_comb begin
		r_nxt = r_r;
		r_nxt.start_sync  = sync_step(r_r.start_sync, cycle_start_pulse);
		r_nxt.expose_sync = sync_step(r_r.expose_sync, expose_pulse);
		r_nxt.start_d     = r_r.start_sync[1];
		r_nxt.expose_d    = r_r.expose_sync[1];
		r_nxt.out.shutter_trigger = 1'b0;
		r_nxt.out.sampling_pulse  = 1'b0;
		r_nxt.cnt = cnt_step(r_r.cnt); // [R11]
		case (r_r.st)
			cpst_pkg::ST_HOLD: begin
				r_nxt.cnt = '0; // [R7]
			end
			cpst_pkg::ST_PREPARE: begin
				if (expose_edge && !r_r.fired) begin
					r_nxt.out.shutter_trigger = 1'b1; // [R5]
					r_nxt.fired = 1'b1; // [R12]
					r_nxt.st = cpst_pkg::ST_EXPOSE;
				end else if (cnt_reached(r_r.cnt, BACKUP_CYC)) begin
					r_nxt.out.shutter_trigger = 1'b1; // [R6]
					r_nxt.fired = 1'b1; // [R12]
					r_nxt.st = cpst_pkg::ST_EXPOSE;
				end
			end
			cpst_pkg::ST_EXPOSE: begin
				r_nxt.st = cpst_pkg::ST_DEVELOP; // [R2]
			end
			cpst_pkg::ST_DEVELOP: begin
				if (cnt_reached(r_r.cnt, FRONT_CYC)) begin
					r_nxt.st      = cpst_pkg::ST_READOUT; // [R3]
					r_nxt.cnt     = '0;
					r_nxt.smp_cnt = '0;
				end
			end
			cpst_pkg::ST_READOUT: begin
				r_nxt.smp_cnt = r_r.smp_cnt + 20'h1;
				if (smp_reached(r_r.smp_cnt, SAMPLE_CYC)) begin
					r_nxt.smp_cnt = '0;
					r_nxt.out.sampling_pulse = 1'b1; // [R10]
				end
				if (cnt_reached(r_r.cnt, READOUT_CYC)) begin
					r_nxt.st = cpst_pkg::ST_HOLD; // [R7]
					r_nxt.cnt = '0;
					r_nxt.out.sampling_pulse = 1'b0;
				end
			end
			default: begin
				r_nxt.st = cpst_pkg::ST_HOLD;
			end
		endcase
		// start pulse ends hold and restarts a full cycle
		if (start_edge) begin
			r_nxt = restart_cycle(r_nxt); // [R1] [R8]
		end
		// phase levels follow the next state so they change with it
		r_nxt.out = phase_flags(r_nxt.st, r_nxt.out.shutter_trigger,
			r_nxt.out.sampling_pulse); // [R2]
	end

	////////////////////////////////////////////////////////////////////////
	// registers
	always_ff @(posedge core_clk) begin
		if (srst) begin
			r_r <= reset_regs();
		end else begin
			r_r <= r_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outputs straight from the state register
	assign cam_out = r_r.out;

	// PREPARE_CYC documents the expected expose time for the command side
	logic unused_prep;
	assign unused_prep = ^PREPARE_CYC;

endmodule

// >>> cpst_timer_sva.sv
// Purpose: cpst_timer port checker
// Assumes: one clock domain
// Notes: bound at foot
`timescale 1ns/1ns
module cpst_timer_sva (
	input wire logic	core_clk,
	input wire logic	srst,
	input wire logic	cycle_start_pulse,
	input cpst_pkg::cpst_out_t	cam_out
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (srst);
	a_shut_in_exp: assert property (cam_out.shutter_trigger |-> cam_out.expose_active)
		else $error("shutter");
	a_smp_in_ro: assert property (cam_out.sampling_pulse |-> cam_out.readout_active)
		else $error("sample");
	a_phase_hot: assert property ($onehot(cam_out[4:0]))
		else $error("phase");
	a_exp_dev: assert property ($rose(cam_out.expose_active) |=> cam_out.develop_active)
		else $error("develop");
	a_shut_once: assert property (cam_out.shutter_trigger |=> !cam_out.shutter_trigger[*8])
		else $error("twice");
	a_start_prep: assert property ($rose(cycle_start_pulse) |-> ##[3:5] cam_out.prepare_active)
		else $error("start");
	a_hold_exit: assert property ($fell(cam_out.hold_active) |-> cam_out.prepare_active)
		else $error("hold");
	a_ro_entry: assert property ($rose(cam_out.readout_active) |-> $past(cam_out.develop_active))
		else $error("readout");
endmodule
bind cpst_timer cpst_timer_sva u_sva (.core_clk(core_clk), .srst(srst),
	.cycle_start_pulse(cycle_start_pulse), .cam_out(cam_out));

// >>> cpst_cmd.sv
// Purpose: command side model
// Assumes: steps on falling edge
// Notes: expose sent dly cycles after start
`timescale 1ns/1ns
module cpst_cmd (
	input wire logic	core_clk,
	input wire logic	go,
	input wire logic	ex_en,
	input wire logic [7:0]	dly,
	output logic	st = 1'b0,
	output logic	ex = 1'b0
);
	int c = 255;
	always @(negedge core_clk) begin
		c <= go ? 0 : (c < 255 ? c + 1 : c);
		st <= go;
		ex <= ex_en && c >= dly && c < dly + 3;
	end
endmodule

// >>> cpst_timer_tb.sv
// Purpose: cpst_timer bench
// Assumes: counts shortened
// Notes: expose missing, late or random
`timescale 1ns/1ns
module cpst_timer_tb;
	localparam int FRONT = 100, RO = 400, BK = 60, SMP = 10;
	logic clk = 1'b0, srst = 1'b1, go = 1'b0, en = 1'b0;
	logic [7:0] dly = 8'h00;
	logic st, ex;
	cpst_pkg::cpst_out_t o;
	int errors = 0, samples_checked = 0, seed = 32'hF8B5D9F9;
	int n, t, sh, pe, ro, sp;
	cpst_cmd u_cpst_cmd (.core_clk(clk), .go(go), .ex_en(en), .dly(dly), .st(st), .ex(ex));
	cpst_timer #(.FRONT_CYC(36'h64), .READOUT_CYC(36'h190), .BACKUP_CYC(36'h3C),
		.SAMPLE_CYC(20'hA)) u_cpst_timer (.core_clk(clk), .srst(srst),
		.cycle_start_pulse(st), .expose_pulse(ex), .cam_out(o));
	initial forever #5 clk = ~clk;
	function automatic logic nr(int a, int b);
		return a >= b - 2 && a <= b + 2;
	endfunction
	task automatic check(logic [35:0] s, logic [35:0] e);
		samples_checked++;
		if (s !== e) begin
			errors++;
			$display("BAD t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task automatic report_and_stop;
		$display("errors=%0d samples_checked=%0d", errors, samples_checked);
		if (errors == 0 && samples_checked > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task automatic run(logic e, logic [7:0] d);
		en <= e;
		dly <= d;
		go <= 1'b1;
		repeat (3) @(negedge clk);
		go <= 1'b0;
		{t, sh, pe, ro, sp} = '0;
		for (n = 0; n < 1000 && !(o.hold_active && ro > 0); n++) begin
			@(negedge clk);
			if (o.shutter_trigger) t = pe;
			sh += o.shutter_trigger;
			pe += o.prepare_active | o.expose_active | o.develop_active;
			ro += o.readout_active;
			sp += o.sampling_pulse;
		end
		if (n == 1000) errors++;
		if (n == 1000) report_and_stop();
		check(sh, 1);
		check(nr(t, (e && d + 1 < BK) ? d + 1 : BK), 1'b1);
		check(nr(pe, FRONT), 1'b1);
		check(ro, RO);
		check(nr(sp, RO / SMP), 1'b1);
		repeat (50) @(negedge clk);
		check(o.hold_active, 1'b1);
	endtask
	initial begin
		repeat (10) @(negedge clk);
		srst <= 1'b0;
		check(o.hold_active, 1'b1);
		run(1'b0, 8'h14);
		run(1'b1, 8'h46);
		repeat (5) run(1'($random(seed)), 8'(15 + ($random(seed) & 31)));
		report_and_stop();
	end
endmodule
